// ### rtl/tmrpw_pkg.sv
// constants, register map and types for the one-shot / pwm timer
package tmrpw_pkg;
   localparam int          CNT_W        = 16;
   localparam int          NCH          = 4;
   localparam int          APB_AW       = 8;
   localparam int          DATA_W       = 32;
   localparam int          MODE_W       = 3;
   localparam int          AUX_W        = 8;
   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_IOC2    = 8'h04;
   localparam logic [7:0]  ADDR_OPT     = 8'h08;
   localparam logic [7:0]  ADDR_CNT     = 8'h0C;
   localparam logic [7:0]  ADDR_CMP0    = 8'h10;
   localparam logic [7:0]  ADDR_CMP3    = 8'h1C;
   localparam logic [7:0]  ADDR_STAT    = 8'h20;
   localparam int          CMP_SHIFT    = 2;
   // control field positions
   localparam int          CTRL_MODE_LO = 0;
   localparam int          CTRL_MODE_HI = 2;
   localparam int          CTRL_EN_BIT  = 7;
   localparam int          CTRL_SWT_BIT = 8;
   localparam int          CTRL_EDG_BIT = 9;
   // status field positions
   localparam int          STAT_ARM_BIT = 0;
   localparam int          STAT_ST_LO   = 1;
   localparam int          STAT_ST_HI   = 2;
   // mode encodings
   localparam logic [2:0]  MODE_ONESHOT = 3'h3;
   localparam logic [2:0]  MODE_PWM     = 3'h4;
   // counter values and reset values
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [15:0] CMP_RST      = 16'h0000;
   localparam logic [7:0]  AUX_RST      = 8'h00;
   localparam logic [31:0] RD_ZERO      = 32'h00000000;

   // gray coded along idle -> wait -> run
   typedef enum logic [1:0] {
      TMRPW_IDLE = 2'h0,
      TMRPW_WAIT = 2'h1,
      TMRPW_RUN  = 2'h3
   } tmrpw_state_t;
endpackage

// ### rtl/tmrpw_ch_if.sv
// link between the timer core and one compare channel
`timescale 1ns/1ps
interface tmrpw_ch_if;
   logic        wr_en;
   logic [15:0] wr_data;
   logic        load;
   logic [15:0] reg_val;
   logic [15:0] shadow_val;

   modport core (output wr_en, output wr_data, output load,
                 input reg_val, input shadow_val);
   modport chan (input wr_en, input wr_data, input load,
                 output reg_val, output shadow_val);
endinterface

// ### rtl/tmrpw_compare_chan.sv
// one compare register with its shadow copy
`timescale 1ns/1ps
module tmrpw_compare_chan
   import tmrpw_pkg::*;
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   tmrpw_ch_if.chan   ch
);
   logic [15:0] next_reg;
   logic [15:0] next_shadow;
   logic [15:0] cmp_reg;
   logic [15:0] cmp_shadow;

   // shadow takes the old register value when a write and a load collide
   always_comb begin
      next_reg    = ch.wr_en ? ch.wr_data : cmp_reg;
      next_shadow = ch.load ? cmp_reg : cmp_shadow;
   end

   // register and shadow storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_reg    <= CMP_RST;
         cmp_shadow <= CMP_RST;
      end else begin
         cmp_reg    <= next_reg;
         cmp_shadow <= next_shadow;
      end
   end

   assign ch.reg_val    = cmp_reg;
   assign ch.shadow_val = cmp_shadow;
endmodule

// ### rtl/tmrpw_trig_sync.sv
// trigger pin synchroniser and edge detector
`timescale 1ns/1ps
module tmrpw_trig_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic trig_pin,
   input  wire logic fall_edge,
   output logic      trig_pulse
);
   logic sync_a;
   logic sync_b;
   logic sync_old;
   logic next_pulse;

   // edge seen only on the second stage and its delayed copy
   always_comb begin
      next_pulse = fall_edge ? (sync_old & ~sync_b) : (~sync_old & sync_b);
   end

   // two-stage synchroniser, history and pulse register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a     <= 1'b0;
         sync_b     <= 1'b0;
         sync_old   <= 1'b0;
         trig_pulse <= 1'b0;
      end else begin
         sync_a     <= trig_pin;
         sync_b     <= sync_a;
         sync_old   <= sync_b;
         trig_pulse <= next_pulse;
      end
   end
endmodule

// ### rtl/tmrpw_timer.sv
// 16-bit timer with one-shot pulse and pwm output modes, apb register port
`timescale 1ns/1ps
//
// Function
// [RULE1] software reads the live 16-bit count any time, read only
// [RULE2] one-shot: output k delayed D_k clocks, active D_0-D_k+1 clocks
// [RULE3] one-shot: no pulse on a channel whose compare exceeds channel 0
// [RULE4] second io control and option registers have no effect in either mode
// [RULE5] software stops the counter before lowering compare values in one-shot
// [RULE6] one-shot compares new values at once; past value means wrap and continue
// [RULE7] one-shot: match k raises irq k, sets output; match 0 ends pulse, stops
// [RULE8] one-shot: irq k pulses in the very cycle of the match
// [RULE9] pwm mode 100 plus enable: counter FFFF to 0000, pwm on channels 1-3
// [RULE10] pwm: output 0 toggles every pwm cycle
// [RULE11] pwm: cycle D_0+1 clocks, active width D_k clocks
// [RULE12] pwm: new compare values apply only at the clear on channel 0 match; code also loads all shadows when pwm starts from idle
// [RULE13] pwm: irq 0 with the clear step, irq k in the match cycle
// [RULE14] pwm: shadows load at the next clear only after channel 1 is written
// [RULE15] software writes compare 1 last; cycle change rewrites compare 1 too
// [RULE16] duty change of channel 1 alone needs only compare 1 written
// [RULE17] no compare write after compare 1 until irq 0 has occurred
// [RULE18] mode field 011 selects one-shot pulse mode
// [RULE19] one-shot starts on trigger pin edge or software trigger bit
// [RULE20] one-shot ignores triggers while a pulse is running
// [RULE21] after a one-shot pulse counter goes to FFFF, stops, awaits trigger
// [RULE22] counter steps on each count tick while running, holds when disabled
module tmrpw_timer
   import tmrpw_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [tmrpw_pkg::APB_AW-1:0] paddr,
   input  wire logic [tmrpw_pkg::DATA_W-1:0] pwdata,
   output logic      [tmrpw_pkg::DATA_W-1:0] prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     count_tick,
   input  wire logic                     ext_trigger,
   output logic                          output_channel_0,
   output logic      [tmrpw_pkg::NCH-1:1] output_channel_k,
   output logic                          match_irq_0,
   output logic      [tmrpw_pkg::NCH-1:1] match_irq_k
);
   import tmrpw_pkg::*;

   tmrpw_ch_if ch [NCH] ();

   logic [MODE_W-1:0] mode_select_field;
   logic              count_enable_bit;
   logic              fall_edge;
   logic [AUX_W-1:0]  io_control_second;
   logic [AUX_W-1:0]  option_settings;
   logic [MODE_W-1:0] next_mode;
   logic              next_enable;
   logic              next_fall;
   logic [AUX_W-1:0]  next_ioc2;
   logic [AUX_W-1:0]  next_opt;
   logic [DATA_W-1:0] next_prdata;
   logic              next_slverr;

   logic              acc;
   logic              wr_acc;
   logic              soft_trigger_bit;
   logic [NCH-1:0]    cmp_wr;
   logic [15:0]       cmp_reg    [NCH];
   logic [15:0]       cmp_shadow [NCH];
   logic [15:0]       cmp_eff    [NCH];

   tmrpw_state_t      state;
   tmrpw_state_t      next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [CNT_W-1:0]  nc;
   logic              armed;
   logic              next_armed;
   logic              pend;
   logic              next_pend;
   logic              load_all;
   logic              next_out0;
   logic [NCH-1:1]    next_outk;
   logic              next_irq0;
   logic [NCH-1:1]    next_irqk;
   logic              trig_pulse;
   logic              trig_now;
   logic              mode_os;
   logic              mode_pwm;
   logic              step;

   // zero-wait slave: every access phase completes at once
   assign pready = 1'b1;
   assign acc    = psel & penable;
   assign wr_acc = acc & pwrite;
   assign soft_trigger_bit = wr_acc & (paddr == ADDR_CTRL) & pwdata[CTRL_SWT_BIT];

   tmrpw_trig_sync u_trig (
      .pclk       (pclk),
      .presetn    (presetn),
      .trig_pin   (ext_trigger),
      .fall_edge  (fall_edge),
      .trig_pulse (trig_pulse)
   );

   // one compare channel per index, channel 0 sets the cycle
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         assign cmp_wr[gi]        = wr_acc &
                                    (paddr == ADDR_CMP0 + APB_AW'(gi << CMP_SHIFT));
         assign ch[gi].wr_en      = cmp_wr[gi];
         assign ch[gi].wr_data    = pwdata[CNT_W-1:0];
         assign ch[gi].load       = load_all;
         assign cmp_reg[gi]       = ch[gi].reg_val;
         assign cmp_shadow[gi]    = ch[gi].shadow_val;
         // the compare seen by the next count, load included
         assign cmp_eff[gi]       = load_all ? ch[gi].reg_val : ch[gi].shadow_val;
         tmrpw_compare_chan u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .ch      (ch[gi].chan)
         );
      end
   endgenerate

   // control and auxiliary register writes
   always_comb begin
      next_mode   = mode_select_field;
      next_enable = count_enable_bit;
      next_fall   = fall_edge;
      next_ioc2   = io_control_second;
      next_opt    = option_settings;
      if (wr_acc && paddr == ADDR_CTRL) begin
         next_mode   = pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
         next_enable = pwdata[CTRL_EN_BIT];
         next_fall   = pwdata[CTRL_EDG_BIT];
      end else if (wr_acc && paddr == ADDR_IOC2) begin
         next_ioc2 = pwdata[AUX_W-1:0];
      end else if (wr_acc && paddr == ADDR_OPT) begin
         next_opt = pwdata[AUX_W-1:0];
      end
   end

   // read data captured in the setup cycle, ready in the access cycle
   always_comb begin
      next_prdata = RD_ZERO;
      next_slverr = 1'b0;
      if (paddr == ADDR_CTRL) begin
         next_prdata[CTRL_MODE_HI:CTRL_MODE_LO] = mode_select_field;
         next_prdata[CTRL_EN_BIT]               = count_enable_bit;
         next_prdata[CTRL_EDG_BIT]              = fall_edge;
      end else if (paddr == ADDR_IOC2) begin
         next_prdata[AUX_W-1:0] = io_control_second; // RULE4
      end else if (paddr == ADDR_OPT) begin
         next_prdata[AUX_W-1:0] = option_settings; // RULE4
      end else if (paddr == ADDR_CNT) begin
         next_prdata[CNT_W-1:0] = cnt; // RULE1
         next_slverr            = pwrite;
      end else if (paddr >= ADDR_CMP0 && paddr <= ADDR_CMP3 && paddr[1:0] == 2'h0) begin
         next_prdata[CNT_W-1:0] = cmp_reg[paddr[CMP_SHIFT+1:CMP_SHIFT]];
      end else if (paddr == ADDR_STAT) begin
         next_prdata[STAT_ARM_BIT]            = armed;
         next_prdata[STAT_ST_HI:STAT_ST_LO]   = state;
      end else begin
         next_slverr = 1'b1;
      end
   end

   // register file and bus answer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_select_field <= MODE_ONESHOT ^ MODE_ONESHOT;
         count_enable_bit  <= 1'b0;
         fall_edge         <= 1'b0;
         io_control_second <= AUX_RST;
         option_settings   <= AUX_RST;
         prdata            <= RD_ZERO;
         pslverr           <= 1'b0;
      end else begin
         mode_select_field <= next_mode;
         count_enable_bit  <= next_enable;
         fall_edge         <= next_fall;
         io_control_second <= next_ioc2;
         option_settings   <= next_opt;
         if (psel && !penable) begin
            prdata  <= pwrite ? RD_ZERO : next_prdata;
            pslverr <= next_slverr;
         end
      end
   end

   // counter, mode sequencing, outputs and match pulses
   always_comb begin
      mode_os    = (mode_select_field == MODE_ONESHOT); // RULE18
      mode_pwm   = (mode_select_field == MODE_PWM);
      trig_now   = trig_pulse | soft_trigger_bit; // RULE19
      next_state = state;
      next_cnt   = cnt;
      nc         = cnt;
      step       = 1'b0;
      load_all   = 1'b0;
      next_pend  = 1'b0;
      next_out0  = output_channel_0;
      next_outk  = output_channel_k;
      next_irq0  = 1'b0;
      next_irqk  = '0;
      case (state)
         TMRPW_IDLE: begin
            next_out0 = 1'b0;
            next_outk = '0;
            if (count_enable_bit && (mode_os || mode_pwm)) begin
               next_state = TMRPW_WAIT;
               next_cnt   = CNT_MAX; // RULE9
               load_all   = mode_pwm; // pwm starts from fresh shadows
            end
         end
         TMRPW_WAIT: begin
            next_cnt = CNT_MAX; // RULE21
            if (mode_os) begin
               // a trigger may land before the next count tick
               next_pend = ~count_tick & (pend | trig_now);
               step      = count_tick & (pend | trig_now);
            end else begin
               step = count_tick;
            end
            if (step) begin
               nc         = CNT_ZERO; // RULE9
               next_state = TMRPW_RUN;
               next_out0  = mode_os ? 1'b1 : output_channel_0;
            end
         end
         default: begin // run; triggers here are never looked at
            if (count_tick) begin // RULE20
               step = 1'b1;
               if (mode_os && cnt == cmp_reg[0]) begin
                  // pulse done: stop at the top and wait again
                  step       = 1'b0;
                  next_cnt   = CNT_MAX; // RULE21
                  next_state = TMRPW_WAIT;
                  next_out0  = 1'b0;
                  next_outk  = '0; // RULE7
                  next_irq0  = 1'b1; // RULE7
               end else if (mode_pwm && cnt == cmp_shadow[0]) begin
                  nc        = CNT_ZERO; // RULE12
                  load_all  = armed; // RULE14
                  next_irq0 = 1'b1; // RULE13
                  next_out0 = ~output_channel_0; // RULE10
               end else begin
                  nc = cnt + CNT_ONE; // RULE22 RULE6
               end
            end
         end
      endcase
      // channel outputs follow the count that is about to be shown
      if (step) begin
         next_cnt = nc;
         for (int k = 1; k < NCH; k++) begin
            if (mode_os) begin
               // live register compare, no shadow in one-shot
               if (nc == cmp_reg[k] && cmp_reg[k] <= cmp_reg[0]) begin // RULE3 RULE6
                  next_outk[k] = 1'b1; // RULE2 RULE7
                  next_irqk[k] = 1'b1; // RULE8
               end
            end else begin
               next_outk[k] = ({1'b0, nc} < {1'b0, cmp_eff[k]}); // RULE11
               next_irqk[k] = (nc == cmp_eff[k]); // RULE13
            end
         end
      end
      // leaving the enabled modes holds the count and drops the outputs
      if (!count_enable_bit || !(mode_os || mode_pwm)) begin
         next_state = TMRPW_IDLE;
         next_cnt   = cnt; // RULE22
         next_out0  = 1'b0;
         next_outk  = '0;
         next_irq0  = 1'b0;
         next_irqk  = '0;
         next_pend  = 1'b0;
         load_all   = 1'b0;
      end
      // a compare 1 write in the load cycle keeps the transfer armed
      next_armed = cmp_wr[1] | (armed & ~load_all); // RULE14
   end

   // sequencer state flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state            <= TMRPW_IDLE;
         cnt              <= CNT_MAX;
         armed            <= 1'b0;
         pend             <= 1'b0;
         output_channel_0 <= 1'b0;
         output_channel_k <= '0;
         match_irq_0      <= 1'b0;
         match_irq_k      <= '0;
      end else begin
         state            <= next_state;
         cnt              <= next_cnt;
         armed            <= next_armed;
         pend             <= next_pend;
         output_channel_0 <= next_out0;
         output_channel_k <= next_outk;
         match_irq_0      <= next_irq0;
         match_irq_k      <= next_irqk;
      end
   end
endmodule

// ### bench/tmrpw_timer_monitor.sv
// concurrent checks on the timer's register port and output timing
`timescale 1ns/1ps
module tmrpw_mon
   import tmrpw_pkg::*;
(
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [tmrpw_pkg::APB_AW-1:0]  paddr,
   input wire logic [tmrpw_pkg::DATA_W-1:0]  pwdata,
   input wire logic [tmrpw_pkg::DATA_W-1:0]  prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire logic                          count_tick,
   input wire logic                          ext_trigger,
   input wire logic                          output_channel_0,
   input wire logic [tmrpw_pkg::NCH-1:1]     output_channel_k,
   input wire logic                          match_irq_0,
   input wire logic [tmrpw_pkg::NCH-1:1]     match_irq_k
);
   logic [2:0] mode_q;
   logic       en_q;
   logic       acc;
   logic       os_on;
   logic       pwm_on;

   assign acc    = psel && penable;
   assign os_on  = en_q && (mode_q == MODE_ONESHOT);
   assign pwm_on = en_q && (mode_q == MODE_PWM);

   // shadow of mode and enable, snooped from control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 3'h0;
         en_q   <= 1'b0;
      end else if (acc && pwrite && paddr == ADDR_CTRL) begin
         mode_q <= pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
         en_q   <= pwdata[CTRL_EN_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cnt_read_width: assert property (acc && !pwrite && paddr == ADDR_CNT |-> pready && prdata[31:16] == 16'h0000) else $error("counter read not a clean 16-bit word");
   a_bad_access: assert property (acc && (paddr > ADDR_STAT || (pwrite && paddr == ADDR_CNT)) |-> pslverr && (pwrite || prdata == RD_ZERO)) else $error("bad access not refused");
   a_good_access: assert property (acc && !pwrite && paddr <= ADDR_STAT && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped read refused");
   a_os_irq_edge: assert property (os_on && $past(os_on) |-> match_irq_k == (output_channel_k & ~$past(output_channel_k))) else $error("one-shot channel irq not with output rise");
   a_os_stop_end: assert property (os_on && $past(os_on) |-> match_irq_0 == $fell(output_channel_0)) else $error("one-shot end irq mismatch");
   a_os_all_low: assert property (os_on && $fell(output_channel_0) |-> output_channel_k == 3'h0) else $error("channel output left high after pulse");
   a_pwm_fall_irq: assert property (pwm_on && $past(pwm_on) |-> ($past(output_channel_k) & ~output_channel_k & ~match_irq_k) == 3'h0) else $error("pwm output fell without irq");
   a_pwm_toggle: assert property (pwm_on && match_irq_0 |-> $changed(output_channel_0)) else $error("pwm clear without square-wave toggle");
   a_tick_hold: assert property (en_q && $past(en_q) && !$past(count_tick) |-> $stable(output_channel_0) && $stable(output_channel_k) && !match_irq_0) else $error("outputs moved without a count tick");

   c_os_end: cover property (os_on && $fell(output_channel_0));
   c_pwm_clear: cover property (pwm_on && match_irq_0);
   c_refused: cover property (acc && pslverr);
endmodule

bind tmrpw_timer tmrpw_mon tmrpw_mon_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_tick(count_tick), .ext_trigger(ext_trigger), .output_channel_0(output_channel_0),
   .output_channel_k(output_channel_k), .match_irq_0(match_irq_0), .match_irq_k(match_irq_k)
);

// ### bench/tb_top.sv
// self-checking bench for the one-shot / pwm timer
`timescale 1ns/1ps
module tb_top;
   import tmrpw_pkg::*;
   localparam logic [31:0] EN = 32'h00000080;
   localparam int          ORD[4] = '{0, 2, 3, 1};
   logic        pclk, presetn, psel, penable, pwrite, count_tick, ext_trigger;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr, output_channel_0, match_irq_0;
   logic [3:1]  output_channel_k, match_irq_k;
   int          n_fail, total_checks, cyc, nd, d[4], hi[4], rise[4], nirq[4];

   tmrpw_timer tmrpw_timer_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_tick(count_tick), .ext_trigger(ext_trigger), .output_channel_0(output_channel_0),
      .output_channel_k(output_channel_k), .match_irq_0(match_irq_0), .match_irq_k(match_irq_k));

   always #5 pclk = ~pclk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard, well above the several hundred cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // channel 1 last, so the shadow load is armed only once all are set
   task automatic set_cmp();
      foreach (ORD[j]) begin
         apb(1'b1, ADDR_CMP0 + 8'(ORD[j] * 4), 32'(d[ORD[j]]));
      end
   endtask

   // sample outputs mid-cycle from the current cycle on, so a pulse that
   // starts at the edge the last transfer ended on is not missed
   task automatic run_meas(input int n, input int pin_at);
      logic [3:0] ov;
      logic [3:0] iv;
      hi   = '{default: 0};
      nirq = '{default: 0};
      rise = '{default: -1};
      for (int i = 0; i < n; i++) begin
         @(negedge pclk);
         ov = {output_channel_k, output_channel_0};
         iv = {match_irq_k, match_irq_0};
         for (int k = 0; k < 4; k++) begin
            if (ov[k] === 1'b1) begin
               hi[k]++;
               if (rise[k] < 0) rise[k] = i;
            end
            if (iv[k] === 1'b1) nirq[k]++;
         end
         @(posedge pclk);
         if (i == pin_at) ext_trigger <= !ext_trigger;
      end
   endtask

   task automatic wait_irq0();
      int i;
      i = 0;
      do begin
         @(negedge pclk);
         i++;
      end while (match_irq_0 !== 1'b1 && i < 2000);
      chk("cycle clear seen", 1, match_irq_0);
   endtask

   function automatic int os_width(input int d0, input int dk);
      return (dk <= d0) ? d0 - dk + 1 : 0;
   endfunction

   task automatic check_os();
      chk("pulse0 width", d[0] + 1, hi[0]);
      chk("irq0 count", 1, nirq[0]);
      for (int k = 1; k < 4; k++) begin
         chk("pulse width", os_width(d[0], d[k]), hi[k]);
         chk("irq count", 32'(d[k] <= d[0]), nirq[k]);
         if (d[k] <= d[0]) chk("pulse delay", d[k], rise[k] - rise[0]);
      end
   endtask

   // two full periods: out0 high for one of them
   task automatic check_pwm();
      chk("square high", d[0] + 1, hi[0]);
      chk("irq0 count", 2, nirq[0]);
      for (int k = 1; k < 4; k++) begin
         chk("duty high", 2 * d[k], hi[k]);
         chk("irq count", (d[k] <= d[0]) ? 2 : 0, nirq[k]);
      end
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      count_tick = 1'b1;
      ext_trigger = 1'b0;
      void'($urandom(32'hA83A233B));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // reset state, unmapped and read-only places
      apb(1'b0, ADDR_CNT, 0);
      chk("counter at reset", 32'h0000FFFF, rdat);
      apb(1'b0, 8'h24, 0);
      chk("unmapped refused", 1, rerr);
      apb(1'b1, ADDR_CNT, 32'h00001234);
      chk("counter write refused", 1, rerr);
      apb(1'b0, ADDR_CMP3, 0);
      chk("compare reset", 0, rdat);
      $display("register test done");
      // one-shot, with the unused registers holding random junk
      apb(1'b1, ADDR_IOC2, $urandom);
      apb(1'b1, ADDR_OPT, $urandom);
      d[0] = $urandom_range(30, 10);
      d[1] = $urandom_range(d[0], 0);
      d[2] = d[0];
      d[3] = d[0] + 1 + $urandom_range(5, 0);
      set_cmp();
      apb(1'b1, ADDR_CTRL, 32'(MODE_ONESHOT) | EN);
      apb(1'b1, ADDR_CTRL, 32'(MODE_ONESHOT) | EN | 32'h00000100);
      run_meas(d[0] + 16, 4);
      check_os();
      apb(1'b0, ADDR_CNT, 0);
      chk("counter after pulse", 32'h0000FFFF, rdat);
      apb(1'b0, ADDR_STAT, 0);
      chk("status after pulse", 32'(1 << STAT_ARM_BIT) | (32'(TMRPW_WAIT) << STAT_ST_LO), rdat);
      apb(1'b1, ADDR_CTRL, 32'(MODE_ONESHOT) | EN | 32'h00000200);
      run_meas(d[0] + 16, 2);
      check_os();
      $display("one-shot test done");
      // pwm with 0% and 100% corner channels
      apb(1'b1, ADDR_CTRL, 0);
      d[0] = $urandom_range(30, 6);
      d[1] = 0;
      d[2] = $urandom_range(d[0], 1);
      d[3] = d[0] + 1;
      set_cmp();
      apb(1'b1, ADDR_CTRL, 32'(MODE_PWM) | EN);
      repeat (40) begin
         @(posedge pclk);
         count_tick <= 1'($urandom);
      end
      @(posedge pclk);
      count_tick <= 1'b1;
      wait_irq0();
      run_meas(2 * d[0] + 2, -1);
      check_pwm();
      // unarmed rewrite must stay out of the shadow
      nd = $urandom_range(d[0], 0);
      apb(1'b1, ADDR_CMP0 + 8'h08, 32'(nd));
      wait_irq0();
      wait_irq0();
      run_meas(2 * d[0] + 2, -1);
      check_pwm();
      // new cycle and duties, armed by writing channel 1 last
      d[0] = $urandom_range(60, 40);
      d[1] = $urandom_range(d[0] + 1, 0);
      d[2] = nd;
      apb(1'b1, ADDR_CMP0, 32'(d[0]));
      apb(1'b1, ADDR_CMP0 + 8'h04, 32'(d[1]));
      wait_irq0();
      wait_irq0();
      run_meas(2 * d[0] + 2, -1);
      check_pwm();
      $display("pwm test done");
      // disabled counter holds whatever the tick does
      apb(1'b1, ADDR_CTRL, 32'(MODE_PWM));
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_CNT, 0);
      nd = rdat;
      repeat (30) begin
         @(posedge pclk);
         count_tick <= 1'($urandom);
      end
      apb(1'b0, ADDR_CNT, 0);
      chk("held count", nd, rdat);
      $display("hold test done");
      test_done();
   end
endmodule
